// ==== design/xtw_timer_wdog.sv ====
// file: low-power periodic timer and watchdog with their register window
`timescale 1ns/1ps
module xtw_timer_wdog (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic rtc_tick_i,
  input wire logic mem_cycle_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic timer_irq_o,
  output logic wdog_rst_o
);
  logic [7:0] cfg_q;
  logic [1:0] psel_q;
  logic [7:0] tcnt_hi_q;
  logic [7:0] tcnt_lo_q;
  logic [7:0] wcnt_hi_q;
  logic [7:0] wcnt_lo_q;
  logic tmr_run_q;
  logic wdg_run_q;
  logic tc_q;
  logic [9:0] div_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic wrst_q;
  logic hit;
  logic [7:0] off;
  logic wr_cfg;
  logic wr_psel;
  logic wr_thi;
  logic wr_tlo;
  logic wr_ctl;
  logic wr_whi;
  logic wr_wlo;
  logic wr_key;
  logic rd_ctl;
  logic key_ok;
  logic key_bad;
  logic tick_ps;
  logic w_tick;
  logic t_load;
  logic w_load;
  logic [15:0] t_reload;
  logic [15:0] w_reload;
  logic [15:0] t_count;
  logic [15:0] w_count;
  logic tmr_exp;
  logic wdg_exp;

  // address decode inside the controller register window
  assign hit = (reg_addr_i[15:8] == xtw_pkg::BASE_HI);
  assign off = reg_addr_i[7:0];
  assign wr_cfg = reg_wr_i && hit && (off == xtw_pkg::OFF_CFG)
                  && !cfg_q[xtw_pkg::CFG_SELF_LOCK];
  assign wr_psel = reg_wr_i && hit && (off == xtw_pkg::OFF_PSEL)
                   && !cfg_q[xtw_pkg::CFG_PSEL_LOCK];
  assign wr_thi = reg_wr_i && hit && (off == xtw_pkg::OFF_TCNT_HI)
                  && !cfg_q[xtw_pkg::CFG_TCNT_LOCK];
  assign wr_tlo = reg_wr_i && hit && (off == xtw_pkg::OFF_TCNT_LO)
                  && !cfg_q[xtw_pkg::CFG_TCNT_LOCK];
  assign wr_whi = reg_wr_i && hit && (off == xtw_pkg::OFF_WCNT_HI)
                  && !cfg_q[xtw_pkg::CFG_WCNT_LOCK];
  assign wr_wlo = reg_wr_i && hit && (off == xtw_pkg::OFF_WCNT_LO)
                  && !cfg_q[xtw_pkg::CFG_WCNT_LOCK];
  assign wr_ctl = reg_wr_i && hit && (off == xtw_pkg::OFF_CTRL);
  assign wr_key = reg_wr_i && hit && (off == xtw_pkg::OFF_KEY)
                  && cfg_q[xtw_pkg::CFG_KEY_EN];
  assign rd_ctl = reg_rd_i && hit && (off == xtw_pkg::OFF_CTRL);
  assign key_ok = wr_key && (reg_wdata_i == xtw_pkg::WDOG_KEY);
  assign key_bad = wr_key && (reg_wdata_i != xtw_pkg::WDOG_KEY);

  // configuration: lock bits only ever set, reserved bit stays zero
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_q <= xtw_pkg::RST_CFG;
    end
    else if (wr_cfg)
    begin
      cfg_q <= (reg_wdata_i & xtw_pkg::CFG_WR_MASK)
               | (cfg_q & xtw_pkg::CFG_LOCK_MASK);
    end
  end

  // prescaler select and count bytes
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      psel_q <= xtw_pkg::RST_PSEL;
      tcnt_hi_q <= xtw_pkg::RST_TCNT_HI;
      tcnt_lo_q <= xtw_pkg::RST_TCNT_LO;
      wcnt_hi_q <= xtw_pkg::RST_WCNT_HI;
      wcnt_lo_q <= xtw_pkg::RST_WCNT_LO;
    end
    else
    begin
      if (wr_psel)
        psel_q <= reg_wdata_i[1:0];
      if (wr_thi)
        tcnt_hi_q <= reg_wdata_i;
      if (wr_tlo)
        tcnt_lo_q <= reg_wdata_i;
      if (wr_whi)
        wcnt_hi_q <= reg_wdata_i;
      if (wr_wlo)
        wcnt_lo_q <= reg_wdata_i;
    end
  end

  // run flags: set by the starting write, held until reset
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tmr_run_q <= 1'b0;
      wdg_run_q <= 1'b0;
    end
    else
    begin
      if (wr_tlo)
        tmr_run_q <= 1'b1;
      if (wr_wlo && tmr_run_q)
        wdg_run_q <= 1'b1;
    end
  end

  // rtc divider, frozen until the timer has been started
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_q <= 10'h000;
    end
    else if (tmr_run_q && rtc_tick_i)
    begin
      div_q <= div_q + 10'h001;
    end
  end

  // prescaled tick selection, reserved code gives no tick
  always_comb
  begin
    tick_ps = 1'b0;
    if (tmr_run_q && rtc_tick_i)
    begin
      unique case (psel_q)
        xtw_pkg::PS_32K: tick_ps = 1'b1;
        xtw_pkg::PS_1K: tick_ps = (div_q[4:0] == xtw_pkg::DIV_1K_LAST);
        xtw_pkg::PS_32HZ: tick_ps = (div_q == xtw_pkg::DIV_32HZ_LAST);
        default: tick_ps = 1'b0;
      endcase
    end
  end

  // timer restart sources and reload value
  assign t_load = wr_tlo || (wr_ctl && tmr_run_q && reg_wdata_i[xtw_pkg::CTRL_RESTART]);
  assign t_reload = wr_tlo ? {tcnt_hi_q, reg_wdata_i}
                  : {(wr_thi ? reg_wdata_i : tcnt_hi_q), tcnt_lo_q};

  // watchdog clock source and stop-mode pause; no power-state gating
  assign w_tick = (cfg_q[xtw_pkg::CFG_WDOG_SRC] ? tick_ps : tmr_exp)
                  && !(cfg_q[xtw_pkg::CFG_STOP_MODE] && mem_cycle_i);
  assign w_load = (wr_wlo && tmr_run_q) || (key_ok && wdg_run_q);
  assign w_reload = wr_wlo ? {wcnt_hi_q, reg_wdata_i} : {wcnt_hi_q, wcnt_lo_q};

  // periodic timer counter
  xtw_cnt16 #(
    .RST_VAL({xtw_pkg::RST_TCNT_HI, xtw_pkg::RST_TCNT_LO})
  ) u_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .run_i(tmr_run_q),
    .load_i(t_load),
    .tick_i(tick_ps),
    .reload_i(t_reload),
    .count_o(t_count),
    .expire_o(tmr_exp)
  );

  // watchdog counter
  xtw_cnt16 #(
    .RST_VAL({xtw_pkg::RST_WCNT_HI, xtw_pkg::RST_WCNT_LO})
  ) u_wdog (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .run_i(wdg_run_q),
    .load_i(w_load),
    .tick_i(w_tick),
    .reload_i(w_reload),
    .count_o(w_count),
    .expire_o(wdg_exp)
  );

  // terminal count flag: a new expiry wins over the clearing read
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tc_q <= 1'b0;
    end
    else if (tmr_exp)
    begin
      tc_q <= 1'b1;
    end
    else if (rd_ctl)
    begin
      tc_q <= 1'b0;
    end
  end

  // interrupt and watchdog reset pulses
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_q <= 1'b0;
      wrst_q <= 1'b0;
    end
    else
    begin
      irq_q <= tmr_exp;
      wrst_q <= wdg_exp || key_bad;
    end
  end

  // registered read data; restart bit, key and unmapped read zero
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      rdata_q <= 8'h00;
      if (hit)
      begin
        unique case (off)
          xtw_pkg::OFF_CFG: rdata_q <= cfg_q;
          xtw_pkg::OFF_PSEL: rdata_q <= {6'h00, psel_q};
          xtw_pkg::OFF_TCNT_HI: rdata_q <= tcnt_hi_q;
          xtw_pkg::OFF_TCNT_LO: rdata_q <= tcnt_lo_q;
          xtw_pkg::OFF_CTRL: rdata_q <= {6'h00, tc_q, 1'b0};
          xtw_pkg::OFF_WCNT_LO: rdata_q <= wcnt_lo_q;
          xtw_pkg::OFF_WCNT_HI: rdata_q <= wcnt_hi_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata_o = rdata_q;
  assign timer_irq_o = irq_q;
  assign wdog_rst_o = wrst_q;

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  property p_irq_follows_expiry;
    tmr_exp |=> timer_irq_o ##1 (timer_irq_o == $past(tmr_exp));
  endproperty
  a_irq_follows_expiry: assert property (p_irq_follows_expiry)
    else $error("timer interrupt missing after expiry");

  property p_no_tick_before_start;
    !tmr_run_q |-> !tick_ps && !tmr_exp;
  endproperty
  a_no_tick_before_start: assert property (p_no_tick_before_start)
    else $error("prescaler ticked before timer start");

  property p_timer_start;
    (wr_tlo && !tmr_run_q) |=> tmr_run_q [*8];
  endproperty
  a_timer_start: assert property (p_timer_start)
    else $error("timer did not start or stopped");

  property p_wdog_needs_timer;
    wdg_run_q |-> tmr_run_q;
  endproperty
  a_wdog_needs_timer: assert property (p_wdog_needs_timer)
    else $error("watchdog running without timer");

  property p_bad_key_reset;
    key_bad |=> wdog_rst_o;
  endproperty
  a_bad_key_reset: assert property (p_bad_key_reset)
    else $error("wrong key did not reset");

  property p_lock_sticky;
    cfg_q[xtw_pkg::CFG_WCNT_LOCK] |=> cfg_q[xtw_pkg::CFG_WCNT_LOCK];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock bit cleared without reset");

  property p_tc_set;
    tmr_exp |=> tc_q;
  endproperty
  a_tc_set: assert property (p_tc_set)
    else $error("terminal count flag not set");

  property p_wcnt_locked;
    (reg_wr_i && hit && off == xtw_pkg::OFF_WCNT_LO && cfg_q[xtw_pkg::CFG_WCNT_LOCK])
      |=> $stable(wcnt_lo_q);
  endproperty
  a_wcnt_locked: assert property (p_wcnt_locked)
    else $error("locked watchdog count was written");

  property p_timer_reload;
    t_load |=> t_count == $past(t_reload);
  endproperty
  a_timer_reload: assert property (p_timer_reload)
    else $error("timer reload value wrong");

  property p_stop_mode;
    (cfg_q[xtw_pkg::CFG_STOP_MODE] && mem_cycle_i && !w_load) |=> $stable(w_count);
  endproperty
  a_stop_mode: assert property (p_stop_mode)
    else $error("watchdog counted in stop mode");

  property p_wdog_expiry;
    wdg_exp |=> wdog_rst_o;
  endproperty
  a_wdog_expiry: assert property (p_wdog_expiry)
    else $error("watchdog expiry gave no reset");

  c_timer_expiry: cover property (tmr_exp ##1 timer_irq_o);
  c_key_touch: cover property (key_ok && wdg_run_q);
  c_wdog_reset: cover property (wdg_exp ##1 wdog_rst_o);
endmodule // xtw_timer_wdog

// ==== shared/xtw_pkg.sv ====
// package: register map, field positions, reset values and counts of the timer/watchdog
package xtw_pkg;
  // register window: base high byte and offsets
  localparam logic [7:0] BASE_HI = 8'h1f;
  localparam logic [7:0] OFF_CFG = 8'h01;
  localparam logic [7:0] OFF_PSEL = 8'h02;
  localparam logic [7:0] OFF_TCNT_HI = 8'h03;
  localparam logic [7:0] OFF_TCNT_LO = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h05;
  localparam logic [7:0] OFF_WCNT_LO = 8'h06;
  localparam logic [7:0] OFF_KEY = 8'h07;
  localparam logic [7:0] OFF_SCRATCH = 8'h08;
  localparam logic [7:0] OFF_WCNT_HI = 8'h09;
  localparam logic [7:0] OFF_CHIPREV = 8'h10;

  // configuration field positions
  localparam int CFG_STOP_MODE = 6;
  localparam int CFG_KEY_EN = 5;
  localparam int CFG_WDOG_SRC = 4;
  localparam int CFG_WCNT_LOCK = 3;
  localparam int CFG_TCNT_LOCK = 2;
  localparam int CFG_PSEL_LOCK = 1;
  localparam int CFG_SELF_LOCK = 0;
  localparam logic [7:0] CFG_LOCK_MASK = 8'h0f;
  localparam logic [7:0] CFG_WR_MASK = 8'h7f;

  // control field positions
  localparam int CTRL_RESTART = 0;
  localparam int CTRL_TC = 1;

  // values after reset
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [1:0] RST_PSEL = 2'h0;
  localparam logic [7:0] RST_TCNT_HI = 8'hff;
  localparam logic [7:0] RST_TCNT_LO = 8'hff;
  localparam logic [7:0] RST_WCNT_HI = 8'h00;
  localparam logic [7:0] RST_WCNT_LO = 8'h0f;

  // prescaler selects and divider terminal counts (rtc ticks)
  localparam logic [1:0] PS_32K = 2'h0;
  localparam logic [1:0] PS_1K = 2'h1;
  localparam logic [1:0] PS_32HZ = 2'h2;
  localparam logic [4:0] DIV_1K_LAST = 5'h1f;
  localparam logic [9:0] DIV_32HZ_LAST = 10'h3ff;

  // watchdog key value
  localparam logic [7:0] WDOG_KEY = 8'h5c;
endpackage : xtw_pkg

// ==== design/xtw_cnt16.sv ====
// file: 16-bit reloading down counter shared by the timer and the watchdog
`timescale 1ns/1ps
module xtw_cnt16 #(
  parameter logic [15:0] RST_VAL = 16'hffff
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic load_i,
  input wire logic tick_i,
  input wire logic [15:0] reload_i,
  output logic [15:0] count_o,
  output logic expire_o
);
  logic [15:0] count_q;

  // reaching zero on a tick ends the period
  assign expire_o = run_i && tick_i && !load_i && (count_q <= 16'h0001);
  assign count_o = count_q;

  // count down, reload on restart or on reaching zero
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_q <= RST_VAL;
    end
    else if (load_i || expire_o)
    begin
      count_q <= reload_i;
    end
    else if (run_i && tick_i)
    begin
      count_q <= count_q - 16'h0001;
    end
  end
endmodule // xtw_cnt16

// ==== tb/xtw_ec_model.sv ====
// controller-side model: rtc tick source, wake-up and reset request counters
`timescale 1ns/1ps
module xtw_ec_model #(
  parameter int TICK_DIV = 305
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic timer_irq_i,
  input wire logic wdog_rst_i,
  output logic rtc_tick_o,
  output int wake_cnt_o,
  output int rst_cnt_o
);
  int div_q;

  // one-cycle rtc tick every TICK_DIV clocks
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_q <= 0;
      rtc_tick_o <= 1'b0;
    end
    else
    begin
      div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
      rtc_tick_o <= (div_q == TICK_DIV - 1);
    end
  end

  // every timer interrupt is a periodic wake-up, every reset request is counted
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wake_cnt_o <= 0;
      rst_cnt_o <= 0;
    end
    else
    begin
      wake_cnt_o <= wake_cnt_o + int'(timer_irq_i);
      rst_cnt_o <= rst_cnt_o + int'(wdog_rst_i);
    end
  end
endmodule // xtw_ec_model

// ==== tb/tb_top.sv ====
// testbench: register, timer and watchdog scenarios
`timescale 1ns/1ps
module tb_top;
  localparam int TP = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic mem = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic tick, irq, wrst;
  int wake, rsts;
  int bad_count = 0;
  int cmp_count = 0;

  // 10 MHz clock
  always #50 mclk = ~mclk;

  xtw_timer_wdog u_dut (.mclk_i(mclk), .rst_n_i(rst_n), .rtc_tick_i(tick),
    .mem_cycle_i(mem), .reg_addr_i(addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .timer_irq_o(irq), .wdog_rst_o(wrst));

  xtw_ec_model #(.TICK_DIV(TP)) u_ec (.mclk_i(mclk), .rst_n_i(rst_n),
    .timer_irq_i(irq), .wdog_rst_i(wrst), .rtc_tick_o(tick), .wake_cnt_o(wake),
    .rst_cnt_o(rsts));

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= {xtw_pkg::BASE_HI, a};
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= {xtw_pkg::BASE_HI, a};
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    check($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, exp});
  endtask

  // counts clocks until the chosen pulse, lim if it never comes
  task automatic wait_pulse(input bit dog, input int lim, output int n);
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end while ((dog ? wrst : irq) !== 1'b1 && n < lim);
  endtask

  function automatic logic [15:0] exp_period(input int n, input logic [1:0] ps);
    int d;
    d = (ps == xtw_pkg::PS_32K) ? 1 : (ps == xtw_pkg::PS_1K) ? 32 : 1024;
    return 16'((n < 2 ? 1 : n) * TP * d);
  endfunction

  function automatic logic [15:0] in_rng(input int n, input int lo, input int hi);
    return {15'h0000, n >= lo && n <= hi};
  endfunction

  // main sequence
  initial
  begin
    int n, p, k, w0;
    logic [1:0] ps;
    logic [7:0] ro[9];
    logic [7:0] rv[9];
    logic [7:0] lo_a[5];
    logic [7:0] lo_v[5];
    ro = '{xtw_pkg::OFF_CFG, xtw_pkg::OFF_PSEL, xtw_pkg::OFF_TCNT_HI, xtw_pkg::OFF_TCNT_LO,
      xtw_pkg::OFF_CTRL, xtw_pkg::OFF_WCNT_LO, xtw_pkg::OFF_WCNT_HI, xtw_pkg::OFF_KEY, 8'h20};
    rv = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00};
    lo_a = '{xtw_pkg::OFF_CFG, xtw_pkg::OFF_PSEL, xtw_pkg::OFF_TCNT_HI,
      xtw_pkg::OFF_TCNT_LO, xtw_pkg::OFF_WCNT_LO};
    lo_v = '{8'h0f, 8'h00, 8'hff, 8'hff, 8'h0f};
    void'($urandom(32'h8475fd2e));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (ro[i]) rd_chk(ro[i], rv[i]);
    // nothing runs before the timer low byte is written
    wr(xtw_pkg::OFF_CFG, 8'h10);
    wr(xtw_pkg::OFF_WCNT_LO, 8'h01);
    wait_pulse(1, 300, n);
    check("wdog idle", 16'(n), 16'd300);
    wait_pulse(0, 300, n);
    check("timer idle", 16'(n), 16'd300);
    // periods for every prescale select and a count of 16'h0100 that uses the high byte
    for (k = 0; k < 5; k++)
    begin
      ps = k[1:0];
      n = (k < 2) ? 2 + $urandom_range(5) : (k == 4) ? 16'h0100 : 1;
      wr(xtw_pkg::OFF_PSEL, {6'h00, ps});
      wr(xtw_pkg::OFF_TCNT_HI, n[15:8]);
      wr(xtw_pkg::OFF_TCNT_LO, n[7:0]);
      wait_pulse(0, 5000, p);
      wait_pulse(0, 5000, p);
      check("period", 16'(p), (ps == 2'h3) ? 16'd5000 : exp_period(n, ps));
    end
    // terminal count flag, restart bit reads zero; stale flag cleared first
    wr(xtw_pkg::OFF_TCNT_HI, 8'h00);
    rd_chk(xtw_pkg::OFF_CTRL, 8'h02);
    wr(xtw_pkg::OFF_TCNT_LO, 8'h04);
    wait_pulse(0, 100, n);
    check("tc wait", in_rng(n, 1, 99), 16'h0001);
    rd_chk(xtw_pkg::OFF_CTRL, 8'h02);
    rd_chk(xtw_pkg::OFF_CTRL, 8'h00);
    // repeated restarts hold off expiry
    for (k = 0; k < 24; k++)
    begin
      wr(k[0] ? xtw_pkg::OFF_CTRL : xtw_pkg::OFF_TCNT_LO, k[0] ? 8'h01 : 8'h03);
      if (k == 1)
        w0 = wake;
      repeat (6) @(posedge mclk);
    end
    check("restart", 16'(wake), 16'(w0));
    // watchdog on timer expiries
    wr(xtw_pkg::OFF_CFG, 8'h00);
    wr(xtw_pkg::OFF_WCNT_HI, 8'h00);
    wr(xtw_pkg::OFF_WCNT_LO, 8'h08);
    wait_pulse(1, 300, n);
    check("wdog span", in_rng(n, 84, 100), 16'h0001);
    wr(xtw_pkg::OFF_CFG, 8'h20);
    w0 = rsts;
    for (k = 0; k < 30; k++)
    begin
      wr(xtw_pkg::OFF_KEY, xtw_pkg::WDOG_KEY);
      repeat (8) @(posedge mclk);
    end
    check("key touch", 16'(rsts), 16'(w0));
    wr(xtw_pkg::OFF_KEY, 8'h11);
    wait_pulse(1, 4, n);
    check("bad key", 16'(n), 16'd1);
    wr(xtw_pkg::OFF_WCNT_LO, 8'h08);
    wr(xtw_pkg::OFF_CFG, 8'h00);
    wr(xtw_pkg::OFF_KEY, 8'h11);
    wait_pulse(1, 20, n);
    check("key off", 16'(n), 16'd20);
    // prescaled source, paused by memory cycles in stop mode
    wr(xtw_pkg::OFF_CFG, 8'h50);
    @(posedge mclk);
    mem <= 1'b1;
    wr(xtw_pkg::OFF_WCNT_LO, 8'h08);
    wait_pulse(1, 200, n);
    check("stop mode", 16'(n), 16'd200);
    @(posedge mclk);
    mem <= 1'b0;
    wait_pulse(1, 60, n);
    check("src prescaled", in_rng(n, 26, 38), 16'h0001);
    // locks
    wr(xtw_pkg::OFF_CFG, 8'h18);
    wr(xtw_pkg::OFF_WCNT_LO, 8'h77);
    rd_chk(xtw_pkg::OFF_WCNT_LO, 8'h08);
    wr(xtw_pkg::OFF_CFG, 8'h10);
    rd_chk(xtw_pkg::OFF_CFG, 8'h18);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    wr(xtw_pkg::OFF_CFG, 8'h0f);
    foreach (lo_a[i]) wr(lo_a[i], 8'h52);
    foreach (lo_a[i]) rd_chk(lo_a[i], lo_v[i]);
    results();
  end

  // watchdog against a hang
  initial
  begin
    #(60000 * 100);
    bad_count++;
    results();
  end
endmodule // tb_top
